// ===== logic/vofc_controls.sv
// Video output format control registers and the logic that applies them in the pixel clock domain.
//
// Function
// - Cloche bypass bit: 0 keeps SECAM cloche filter active, 1 bypasses it at DC.
// - Separate 8-bit U and V chroma gain values, nominal zero.
// - Window start: six register bits plus field LSB, 7-bit, zero means line 4.
// - Window end: eight register bits plus field LSB, 9-bit, zero means line 4.
// - One stored LSB serves start and end in even field, another in odd.
// - Two-bit chroma frequency tracking constant, slower to faster, default slower.
// - Two-bit chroma gain tracking constant, slower to faster, default slower.
// - Demodulation mode 0 demodulates; mode 1 bypasses for digital component input.
// - Mode 2 bypasses for analog component and lags Cb half a pixel clock.
// - Mode 3 bypasses for analog component and lags Cr half a pixel clock.
// - Each timing output has its own polarity bit; field polarity also inverts F.
// - Vertical sync polarity also inverts the embedded vertical blanking flag.
// - Range bit 0 clamps luma, chroma and RGB codes to 1 through 254.
// - Range bit 1 clamps luma 16-235, chroma 16-240, RGB 16-240.
// - Inside horizontal window but outside enhanced window, output invalid codes.
// - Outside horizontal window, output separate programmable blank codes.
// - A select bit chooses the colour killer burst threshold.
// - Threshold select 0 means 11 IRE burst level, 1 means 5.5 IRE.
// - Scaler blanking bit 0 runs scaler through vertical blanking; 1 stops it.
`timescale 1ns/1ps
module vofc_controls (
   input  wire logic                    clk,
   input  wire logic                    reset_n,
   input  wire logic [7:0]              reg_index,
   input  wire logic                    reg_write,
   input  wire logic [7:0]              reg_wdata,
   input  wire logic                    reg_read,
   output logic [7:0]                   reg_rdata,
   output logic                         reg_rvalid,
   input  vofc_pkg::vofc_timing_s       timing_in,
   input  wire logic                    vblank_in,
   input  wire logic [9:0]              line_number,
   input  vofc_pkg::vofc_pixel_s        pixel_in,
   input  wire logic                    rgb_mode,
   output vofc_pkg::vofc_timing_s       timing_out,
   output logic                         field_bit,
   output logic                         vblank_bit,
   output logic                         vert_window_hit,
   output vofc_pkg::vofc_pixel_s        pixel_out,
   output logic [7:0]                   u_gain_value,
   output logic [7:0]                   v_gain_value,
   output vofc_pkg::vofc_track_e        chroma_freq_time_const,
   output vofc_pkg::vofc_track_e        chroma_gain_time_const,
   output vofc_pkg::vofc_demod_e        demod_bypass_mode,
   output logic                         demod_bypass,
   output logic                         analog_component,
   output logic                         cb_half_delay,
   output logic                         cr_half_delay,
   output logic                         cloche_bypass,
   output logic                         burst_threshold_select,
   output logic                         auto_chroma_adc_powerdown,
   output logic                         scaler_run,
   output logic [9:0]                   active_start_line,
   output logic [9:0]                   active_end_line
);

   logic [7:0] u_gain_adjust;
   logic [7:0] v_gain_adjust;
   logic [7:0] active_line_start;
   logic [7:0] active_line_end;
   logic [7:0] chroma_tracking_ctrl;
   logic [7:0] timing_polarity_ctrl;
   logic [7:0] output_range_ctrl;
   logic [7:0] invalid_luma_code;
   logic [7:0] invalid_cb_code;
   logic [7:0] invalid_cr_code;
   logic [7:0] blank_luma_code;
   logic [7:0] blank_cb_code;
   logic [7:0] blank_cr_code;
   logic [7:0] extra_chroma_ctrl;

   // Next values of the stored registers.
   logic [7:0] next_u_gain_adjust;
   logic [7:0] next_v_gain_adjust;
   logic [7:0] next_active_line_start;
   logic [7:0] next_active_line_end;
   logic [7:0] next_chroma_tracking_ctrl;
   logic [7:0] next_timing_polarity_ctrl;
   logic [7:0] next_output_range_ctrl;
   logic [7:0] next_invalid_luma_code;
   logic [7:0] next_invalid_cb_code;
   logic [7:0] next_invalid_cr_code;
   logic [7:0] next_blank_luma_code;
   logic [7:0] next_blank_cb_code;
   logic [7:0] next_blank_cr_code;
   logic [7:0] next_extra_chroma_ctrl;

   // Register file: writes land at the edge on which reg_write is high.
   always_comb begin
      next_u_gain_adjust        = u_gain_adjust;
      next_v_gain_adjust        = v_gain_adjust;
      next_active_line_start    = active_line_start;
      next_active_line_end      = active_line_end;
      next_chroma_tracking_ctrl = chroma_tracking_ctrl;
      next_timing_polarity_ctrl = timing_polarity_ctrl;
      next_output_range_ctrl    = output_range_ctrl;
      next_invalid_luma_code    = invalid_luma_code;
      next_invalid_cb_code      = invalid_cb_code;
      next_invalid_cr_code      = invalid_cr_code;
      next_blank_luma_code      = blank_luma_code;
      next_blank_cb_code        = blank_cb_code;
      next_blank_cr_code        = blank_cr_code;
      next_extra_chroma_ctrl    = extra_chroma_ctrl;
      // Unmapped indices fall through and change nothing.
      if (reg_write) begin
         if (reg_index == vofc_pkg::OFS_U_GAIN) begin
            next_u_gain_adjust = reg_wdata;
         end else if (reg_index == vofc_pkg::OFS_V_GAIN) begin
            next_v_gain_adjust = reg_wdata;
         end else if (reg_index == vofc_pkg::OFS_LINE_START) begin
            next_active_line_start = reg_wdata;
         end else if (reg_index == vofc_pkg::OFS_LINE_END) begin
            next_active_line_end = reg_wdata;
         end else if (reg_index == vofc_pkg::OFS_CHROMA_TRACK) begin
            next_chroma_tracking_ctrl = reg_wdata & vofc_pkg::MASK_CHROMA_TRACK;
         end else if (reg_index == vofc_pkg::OFS_POLARITY) begin
            next_timing_polarity_ctrl = reg_wdata;
         end else if (reg_index == vofc_pkg::OFS_RANGE) begin
            next_output_range_ctrl = reg_wdata & vofc_pkg::MASK_RANGE;
         end else if (reg_index == vofc_pkg::OFS_INVALID_Y) begin
            next_invalid_luma_code = reg_wdata;
         end else if (reg_index == vofc_pkg::OFS_INVALID_CB) begin
            next_invalid_cb_code = reg_wdata;
         end else if (reg_index == vofc_pkg::OFS_INVALID_CR) begin
            next_invalid_cr_code = reg_wdata;
         end else if (reg_index == vofc_pkg::OFS_BLANK_Y) begin
            next_blank_luma_code = reg_wdata;
         end else if (reg_index == vofc_pkg::OFS_BLANK_CB) begin
            next_blank_cb_code = reg_wdata;
         end else if (reg_index == vofc_pkg::OFS_BLANK_CR) begin
            next_blank_cr_code = reg_wdata;
         end else if (reg_index == vofc_pkg::OFS_EXTRA) begin
            next_extra_chroma_ctrl = reg_wdata & vofc_pkg::MASK_EXTRA;
         end
      end
   end

   // Reserved bits are dropped on write.
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         u_gain_adjust        <= vofc_pkg::RST_GAIN;
         v_gain_adjust        <= vofc_pkg::RST_GAIN;
         active_line_start    <= vofc_pkg::RST_LINE_START;
         active_line_end      <= vofc_pkg::RST_LINE_END;
         chroma_tracking_ctrl <= vofc_pkg::RST_CHROMA_TRACK;
         timing_polarity_ctrl <= vofc_pkg::RST_POLARITY;
         output_range_ctrl    <= vofc_pkg::RST_RANGE;
         invalid_luma_code    <= vofc_pkg::RST_LUMA_CODE;
         invalid_cb_code      <= vofc_pkg::RST_CHROMA_CODE;
         invalid_cr_code      <= vofc_pkg::RST_CHROMA_CODE;
         blank_luma_code      <= vofc_pkg::RST_LUMA_CODE;
         blank_cb_code        <= vofc_pkg::RST_CHROMA_CODE;
         blank_cr_code        <= vofc_pkg::RST_CHROMA_CODE;
         extra_chroma_ctrl    <= vofc_pkg::RST_EXTRA;
      end else begin
         u_gain_adjust        <= next_u_gain_adjust;
         v_gain_adjust        <= next_v_gain_adjust;
         active_line_start    <= next_active_line_start;
         active_line_end      <= next_active_line_end;
         chroma_tracking_ctrl <= next_chroma_tracking_ctrl;
         timing_polarity_ctrl <= next_timing_polarity_ctrl;
         output_range_ctrl    <= next_output_range_ctrl;
         invalid_luma_code    <= next_invalid_luma_code;
         invalid_cb_code      <= next_invalid_cb_code;
         invalid_cr_code      <= next_invalid_cr_code;
         blank_luma_code      <= next_blank_luma_code;
         blank_cb_code        <= next_blank_cb_code;
         blank_cr_code        <= next_blank_cr_code;
         extra_chroma_ctrl    <= next_extra_chroma_ctrl;
      end
   end

   // Read port: data appears one edge after the strobe; unmapped indices read zero.
   // A read in the same cycle as a write returns the old value.
   logic [7:0] read_mux;
   logic [7:0] next_reg_rdata;
   logic       next_reg_rvalid;

   always_comb begin
      if (reg_index == vofc_pkg::OFS_U_GAIN) begin
         read_mux = u_gain_adjust;
      end else if (reg_index == vofc_pkg::OFS_V_GAIN) begin
         read_mux = v_gain_adjust;
      end else if (reg_index == vofc_pkg::OFS_LINE_START) begin
         read_mux = active_line_start;
      end else if (reg_index == vofc_pkg::OFS_LINE_END) begin
         read_mux = active_line_end;
      end else if (reg_index == vofc_pkg::OFS_CHROMA_TRACK) begin
         read_mux = chroma_tracking_ctrl;
      end else if (reg_index == vofc_pkg::OFS_POLARITY) begin
         read_mux = timing_polarity_ctrl;
      end else if (reg_index == vofc_pkg::OFS_RANGE) begin
         read_mux = output_range_ctrl;
      end else if (reg_index == vofc_pkg::OFS_INVALID_Y) begin
         read_mux = invalid_luma_code;
      end else if (reg_index == vofc_pkg::OFS_INVALID_CB) begin
         read_mux = invalid_cb_code;
      end else if (reg_index == vofc_pkg::OFS_INVALID_CR) begin
         read_mux = invalid_cr_code;
      end else if (reg_index == vofc_pkg::OFS_BLANK_Y) begin
         read_mux = blank_luma_code;
      end else if (reg_index == vofc_pkg::OFS_BLANK_CB) begin
         read_mux = blank_cb_code;
      end else if (reg_index == vofc_pkg::OFS_BLANK_CR) begin
         read_mux = blank_cr_code;
      end else if (reg_index == vofc_pkg::OFS_EXTRA) begin
         read_mux = extra_chroma_ctrl;
      end else begin
         read_mux = 8'h00;
      end
      next_reg_rvalid = reg_read;
      next_reg_rdata  = reg_read ? read_mux : reg_rdata;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rdata  <= next_reg_rdata;
         reg_rvalid <= next_reg_rvalid;
      end
   end

   // Static controls go straight from the stored bits to the datapath.
   assign u_gain_value              = u_gain_adjust;
   assign v_gain_value              = v_gain_adjust;
   assign chroma_freq_time_const    = vofc_pkg::vofc_track_e'(chroma_tracking_ctrl[vofc_pkg::POS_FREQ_TC +: 2]);
   assign chroma_gain_time_const    = vofc_pkg::vofc_track_e'(chroma_tracking_ctrl[vofc_pkg::POS_GAIN_TC +: 2]);
   assign demod_bypass_mode         = vofc_pkg::vofc_demod_e'(chroma_tracking_ctrl[vofc_pkg::POS_DEMOD +: 2]);
   assign cloche_bypass             = extra_chroma_ctrl[vofc_pkg::POS_CLOCHE];
   assign burst_threshold_select    = extra_chroma_ctrl[vofc_pkg::POS_BURST];
   assign auto_chroma_adc_powerdown = extra_chroma_ctrl[vofc_pkg::POS_ADC_PD];

   // The half-period lag needs the falling pixel edge, so it is left to the analog front end as a select.
   always_comb begin
      demod_bypass     = 1'b0;
      analog_component = 1'b0;
      cb_half_delay    = 1'b0;
      cr_half_delay    = 1'b0;
      case (demod_bypass_mode)
         vofc_pkg::VOFC_DEMOD_ON: begin
            demod_bypass = 1'b0;
         end
         vofc_pkg::VOFC_DEMOD_DIGITAL: begin
            demod_bypass = 1'b1;
         end
         vofc_pkg::VOFC_DEMOD_CB_LAG: begin
            demod_bypass     = 1'b1;
            analog_component = 1'b1;
            cb_half_delay    = 1'b1;
         end
         vofc_pkg::VOFC_DEMOD_CR_LAG: begin
            demod_bypass     = 1'b1;
            analog_component = 1'b1;
            cr_half_delay    = 1'b1;
         end
         default: begin
            demod_bypass = 1'b0;
         end
      endcase
   end

   // Window line numbers for the field now being output.
   // Ten bits hold the largest end line with its base added.
   function automatic logic [9:0] window_line(input logic [7:0] upper, input logic lsb);
      window_line = {1'b0, upper, lsb} + vofc_pkg::LINE_BASE;
   endfunction : window_line

   // The limits follow the incoming field flag.
   logic field_lsb;
   logic [9:0] next_active_start_line;
   logic [9:0] next_active_end_line;
   logic       next_vert_window_hit;

   always_comb begin
      field_lsb = timing_in.odd ? active_line_start[vofc_pkg::POS_ODD_LSB]
                                : active_line_start[vofc_pkg::POS_EVEN_LSB];
      next_active_start_line = window_line({2'b00, active_line_start[vofc_pkg::POS_START_MSB:vofc_pkg::POS_START_LSB]},
                                           field_lsb);
      next_active_end_line   = window_line(active_line_end, field_lsb);
      next_vert_window_hit   = (line_number >= next_active_start_line) && (line_number <= next_active_end_line);
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         active_start_line <= vofc_pkg::LINE_BASE;
         active_end_line   <= vofc_pkg::LINE_BASE;
         vert_window_hit   <= 1'b0;
      end else begin
         active_start_line <= next_active_start_line;
         active_end_line   <= next_active_end_line;
         vert_window_hit   <= next_vert_window_hit;
      end
   end

   // Timing outputs: one flop of latency keeps them aligned with the registered pixel data.
   vofc_pkg::vofc_timing_s next_timing_out;
   logic                   next_field_bit;
   logic                   next_vblank_bit;
   logic                   next_scaler_run;

   always_comb begin
      next_timing_out = timing_in ^ timing_polarity_ctrl;
      next_field_bit  = timing_in.odd ^ timing_polarity_ctrl[vofc_pkg::POS_ODD_PL];
      next_vblank_bit = vblank_in ^ timing_polarity_ctrl[vofc_pkg::POS_VS_PL];
      // The scaler itself sits outside; this is only its run request.
      next_scaler_run = timing_in.vert_active_window || !extra_chroma_ctrl[vofc_pkg::POS_SCALER_OFF];
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         timing_out <= '0;
         field_bit  <= 1'b0;
         vblank_bit <= 1'b0;
         scaler_run <= 1'b1;
      end else begin
         timing_out <= next_timing_out;
         field_bit  <= next_field_bit;
         vblank_bit <= next_vblank_bit;
         scaler_run <= next_scaler_run;
      end
   end

   // Substitute codes skip the clamp on purpose.
   vofc_pixel_format u_pixel_format (
      .clk          (clk),
      .reset_n      (reset_n),
      .pixel_in     (pixel_in),
      .horiz_active_window          (timing_in.horiz_active_window),
      .enhanced_horiz_window         (timing_in.enhanced_horiz_window),
      .rgb_mode     (rgb_mode),
      .range_std    (output_range_ctrl[vofc_pkg::POS_RANGE]),
      .invalid_code ({invalid_luma_code, invalid_cb_code, invalid_cr_code}),
      .blank_code   ({blank_luma_code, blank_cb_code, blank_cr_code}),
      .pixel_out    (pixel_out)
   );

endmodule : vofc_controls

// ===== logic/vofc_pixel_format.sv
// Output pixel stage: substitute codes outside the active windows and range clamping.
`timescale 1ns/1ps
module vofc_pixel_format (
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  vofc_pkg::vofc_pixel_s     pixel_in,
   input  wire logic                 horiz_active_window,
   input  wire logic                 enhanced_horiz_window,
   input  wire logic                 rgb_mode,
   input  wire logic                 range_std,
   input  vofc_pkg::vofc_pixel_s     invalid_code,
   input  vofc_pkg::vofc_pixel_s     blank_code,
   output vofc_pkg::vofc_pixel_s     pixel_out
);

   vofc_pkg::vofc_pixel_s next_pixel_out;

   function automatic logic [7:0] clamp_code(input logic [7:0] code,
                                             input logic [7:0] lo,
                                             input logic [7:0] hi);
      if (code < lo) begin
         clamp_code = lo;
      end else if (code > hi) begin
         clamp_code = hi;
      end else begin
         clamp_code = code;
      end
   endfunction : clamp_code

   logic [7:0] lo_lim;
   logic [7:0] y_hi;
   logic [7:0] c_hi;

   always_comb begin
      lo_lim = range_std ? vofc_pkg::STD_MIN : vofc_pkg::FULL_MIN;
      // Under RGB all three components share the wider chroma ceiling.
      y_hi   = !range_std ? vofc_pkg::FULL_MAX : (rgb_mode ? vofc_pkg::STD_C_MAX : vofc_pkg::STD_Y_MAX);
      c_hi   = range_std ? vofc_pkg::STD_C_MAX : vofc_pkg::FULL_MAX;
      if (!horiz_active_window) begin
         next_pixel_out = blank_code;
      end else if (!enhanced_horiz_window) begin
         next_pixel_out = invalid_code;
      end else begin
         next_pixel_out.y = clamp_code(pixel_in.y, lo_lim, y_hi);
         next_pixel_out.u = clamp_code(pixel_in.u, lo_lim, c_hi);
         next_pixel_out.v = clamp_code(pixel_in.v, lo_lim, c_hi);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pixel_out <= '0;
      end else begin
         pixel_out <= next_pixel_out;
      end
   end

endmodule : vofc_pixel_format

// ===== logic/vofc_pkg.sv
// Package with register map, reset values, field layouts and carrier types for the video output controls.
package vofc_pkg;

   localparam logic [7:0] OFS_U_GAIN       = 8'h2B;
   localparam logic [7:0] OFS_V_GAIN       = 8'h2C;
   localparam logic [7:0] OFS_LINE_START   = 8'h2D;
   localparam logic [7:0] OFS_LINE_END     = 8'h2E;
   localparam logic [7:0] OFS_CHROMA_TRACK = 8'h2F;
   localparam logic [7:0] OFS_POLARITY     = 8'h30;
   localparam logic [7:0] OFS_RANGE        = 8'h31;
   localparam logic [7:0] OFS_INVALID_Y    = 8'h32;
   localparam logic [7:0] OFS_INVALID_CB   = 8'h33;
   localparam logic [7:0] OFS_INVALID_CR   = 8'h34;
   localparam logic [7:0] OFS_BLANK_Y      = 8'h35;
   localparam logic [7:0] OFS_BLANK_CB     = 8'h36;
   localparam logic [7:0] OFS_BLANK_CR     = 8'h37;
   localparam logic [7:0] OFS_EXTRA        = 8'h38;

   localparam logic [7:0] RST_GAIN         = 8'h00;
   localparam logic [7:0] RST_LINE_START   = 8'h00;
   localparam logic [7:0] RST_LINE_END     = 8'h00;
   localparam logic [7:0] RST_CHROMA_TRACK = 8'h00;
   localparam logic [7:0] RST_POLARITY     = 8'h00;
   localparam logic [7:0] RST_RANGE        = 8'h00;
   localparam logic [7:0] RST_LUMA_CODE    = 8'h10;
   localparam logic [7:0] RST_CHROMA_CODE  = 8'h80;
   localparam logic [7:0] RST_EXTRA        = 8'h00;

   // Field positions inside the line start register.
   localparam int POS_EVEN_LSB   = 0;
   localparam int POS_ODD_LSB    = 1;
   localparam int POS_START_MSB  = 7;
   localparam int POS_START_LSB  = 2;
   // Field positions inside the chroma tracking register.
   localparam int POS_FREQ_TC    = 0;
   localparam int POS_GAIN_TC    = 2;
   localparam int POS_DEMOD      = 4;
   // Field positions inside the polarity register.
   localparam int POS_HS1_PL     = 0;
   localparam int POS_VAV_PL     = 1;
   localparam int POS_HS2_PL     = 2;
   localparam int POS_ENHANCED_HORIZ_WINDOW_PL    = 3;
   localparam int POS_HAV_PL     = 4;
   localparam int POS_ODD_PL     = 5;
   localparam int POS_VS_PL      = 6;
   localparam int POS_ENHANCED_VERT_WINDOW_PL    = 7;
   // Field positions inside the range and extra registers.
   localparam int POS_RANGE      = 7;
   localparam int POS_BURST      = 0;
   localparam int POS_ADC_PD     = 3;
   localparam int POS_SCALER_OFF = 6;
   localparam int POS_CLOCHE     = 7;

   // Writable bits of registers that carry reserved zeros.
   localparam logic [7:0] MASK_CHROMA_TRACK = 8'h3F;
   localparam logic [7:0] MASK_RANGE        = 8'h80;
   localparam logic [7:0] MASK_EXTRA        = 8'hC9;

   localparam logic [9:0] LINE_BASE = 10'h004;

   localparam logic [7:0] FULL_MIN   = 8'h01;
   localparam logic [7:0] FULL_MAX   = 8'hFE;
   localparam logic [7:0] STD_MIN    = 8'h10;
   localparam logic [7:0] STD_Y_MAX  = 8'hEB;
   localparam logic [7:0] STD_C_MAX  = 8'hF0;

   typedef enum logic [1:0] {
      VOFC_TC_SLOWER = 2'h0,
      VOFC_TC_SLOW   = 2'h1,
      VOFC_TC_FAST   = 2'h2,
      VOFC_TC_FASTER = 2'h3
   } vofc_track_e;

   typedef enum logic [1:0] {
      VOFC_DEMOD_ON      = 2'h0,
      VOFC_DEMOD_DIGITAL = 2'h1,
      VOFC_DEMOD_CB_LAG  = 2'h2,
      VOFC_DEMOD_CR_LAG  = 2'h3
   } vofc_demod_e;

   typedef struct packed {
      logic [7:0] y;
      logic [7:0] u;
      logic [7:0] v;
   } vofc_pixel_s;

   typedef struct packed {
      logic enhanced_vert_window;
      logic vs;
      logic odd;
      logic horiz_active_window;
      logic enhanced_horiz_window;
      logic hs2;
      logic vert_active_window;
      logic hs1;
   } vofc_timing_s;

endpackage : vofc_pkg

// ===== tb/vofc_controls_bench.sv
// Self-checking bench for the video output format controls.
`timescale 1ns/1ps
module vofc_controls_bench;
   logic clk, reset_n, reg_write, reg_read, reg_rvalid, vblank_in, rgb_mode, field_bit, vblank_bit;
   logic vert_window_hit, demod_bypass, analog_component, cb_half_delay, cr_half_delay, cloche_bypass;
   logic burst_threshold_select, auto_chroma_adc_powerdown, scaler_run;
   logic [7:0] reg_index, reg_wdata, reg_rdata, u_gain_value, v_gain_value;
   logic [9:0] line_number, active_start_line, active_end_line;
   vofc_pkg::vofc_timing_s timing_in, timing_out;
   vofc_pkg::vofc_pixel_s  pixel_in, pixel_out;
   vofc_pkg::vofc_track_e  chroma_freq_time_const, chroma_gain_time_const;
   vofc_pkg::vofc_demod_e  demod_bypass_mode;
   int fail_count = 0;
   int checks_done = 0;
   vofc_controls dut_u (.*);
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   task automatic end_of_test();
      if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_index = a;
      reg_wdata = d;
      reg_write = 1'b1;
      @(negedge clk);
      reg_write = 1'b0;
   endtask : wr
   // Read data is taken while the valid pulse stands; a lost pulse ends the run.
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      int n;
      @(negedge clk);
      reg_index = a;
      reg_read = 1'b1;
      @(negedge clk);
      reg_read = 1'b0;
      for (n = 0; n < 4 && reg_rvalid !== 1'b1; n++) @(negedge clk);
      if (n == 4) begin
         chk(24'h0, 24'h1);
         end_of_test();
      end else begin
         chk(reg_rdata, e);
      end
   endtask : rd
   task automatic vid(input logic [7:0] t, input logic [23:0] p);
      @(negedge clk);
      timing_in = t;
      pixel_in = p;
      @(negedge clk);
   endtask : vid
   initial begin
      {reset_n, reg_write, reg_read, vblank_in, rgb_mode} = 5'h00;
      {reg_index, reg_wdata, timing_in, pixel_in} = 48'h0;
      line_number = 10'd14;
      repeat (5) @(negedge clk);
      reset_n = 1'b1;
      chk({active_start_line, active_end_line}, {10'h004, 10'h004});
      for (int i = 8'h2B; i <= 8'h39; i++)
         rd(i[7:0], (i == 8'h32 || i == 8'h35) ? 8'h10 : (i > 8'h32 && i < 8'h38) ? 8'h80 : 8'h00);
      for (int i = 8'h2B; i <= 8'h38; i++) begin
         wr(i[7:0], 8'hFF);
         rd(i[7:0], i == 8'h2F ? 8'h3F : i == 8'h31 ? 8'h80 : i == 8'h38 ? 8'hC9 : 8'hFF);
      end
      chk({u_gain_value, v_gain_value}, 16'hFFFF);
      for (int m = 0; m < 4; m++) begin
         wr(8'h2F, 8'(m * 8'h15));
         chk({chroma_freq_time_const, chroma_gain_time_const, demod_bypass_mode}, 6'(m * 6'h15));
         chk({demod_bypass, analog_component, cb_half_delay, cr_half_delay},
             {m != 0, m > 1, m == 2, m == 3});
      end
      vblank_in = 1'b1;
      for (int j = 0; j < 2; j++) begin
         wr(8'h30, j ? 8'h5A : 8'hA5);
         vid(8'h2F, 24'h0);
         chk({timing_out, field_bit, vblank_bit}, {8'h2F ^ reg_wdata, ~reg_wdata[5], ~reg_wdata[6]});
      end
      wr(8'h30, 8'h00);
      wr(8'h2D, 8'h16);
      wr(8'h2E, 8'h20);
      vid(8'h20, 24'h0);
      chk({active_start_line, active_end_line, vert_window_hit}, {10'd15, 10'd69, 1'b0});
      vid(8'h00, 24'h0);
      chk({active_start_line, active_end_line, vert_window_hit}, {10'd14, 10'd68, 1'b1});
      for (int i = 0; i < 6; i++) wr(8'h32 + 8'(i), 8'h11 * 8'(i + 1));
      wr(8'h31, 8'h00);
      vid(8'h10, 24'h00FF80);
      chk(pixel_out, 24'h112233);
      vid(8'h00, 24'h00FF80);
      chk(pixel_out, 24'h445566);
      vid(8'h18, 24'h00FF80);
      chk(pixel_out, 24'h01FE80);
      wr(8'h31, 8'h80);
      vid(8'h18, 24'hFF0010);
      chk(pixel_out, 24'hEB1010);
      rgb_mode = 1'b1;
      vid(8'h18, 24'hFF0010);
      chk(pixel_out, 24'hF01010);
      wr(8'h38, 8'h81);
      vid(8'h00, 24'h0);
      chk({cloche_bypass, burst_threshold_select, auto_chroma_adc_powerdown, scaler_run}, 4'hD);
      wr(8'h38, 8'h48);
      vid(8'h00, 24'h0);
      chk({cloche_bypass, burst_threshold_select, auto_chroma_adc_powerdown, scaler_run}, 4'h2);
      vid(8'h02, 24'h0);
      chk(scaler_run, 1'b1);
      end_of_test();
   end
endmodule : vofc_controls_bench

// ===== tb/vofc_controls_monitor.sv
// Checker of register and video output relations for the output controls.
`timescale 1ns/1ps
module vofc_controls_monitor (
   input logic                   clk,
   input logic                   reset_n,
   input logic [7:0]             reg_index,
   input logic                   reg_write,
   input logic [7:0]             reg_wdata,
   input logic                   reg_read,
   input logic                   reg_rvalid,
   input vofc_pkg::vofc_timing_s timing_in,
   input logic                   vblank_in,
   input vofc_pkg::vofc_timing_s timing_out,
   input logic                   field_bit,
   input logic                   vblank_bit,
   input vofc_pkg::vofc_pixel_s  pixel_out,
   input logic [7:0]             u_gain_value,
   input vofc_pkg::vofc_demod_e  demod_bypass_mode,
   input logic                   cb_half_delay
);
   // Shadows of the polarity and range registers, so outputs can be tied to their cause.
   logic [7:0] pol_q;
   logic       rng_q;
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n) {pol_q, rng_q} <= 9'h000;
      else if (reg_write && reg_index == 8'h30) pol_q <= reg_wdata;
      else if (reg_write && reg_index == 8'h31) rng_q <= reg_wdata[7];
   default clocking cd @(posedge clk); endclocking
   default disable iff (!reset_n);
   read_pulse_a: assert property ($past(reset_n) |-> reg_rvalid == $past(reg_read))
      else $error("read valid pulse wrong");
   u_gain_write_a: assert property (reg_write && reg_index == 8'h2B |=> u_gain_value == $past(reg_wdata))
      else $error("u gain not written");
   timing_pol_a: assert property ($past(reset_n) |-> timing_out == $past(timing_in ^ pol_q))
      else $error("timing polarity wrong");
   field_flag_a: assert property ($past(reset_n) |-> field_bit == $past(timing_in.odd ^ pol_q[5]))
      else $error("field flag wrong");
   vblank_flag_a: assert property ($past(reset_n) |-> vblank_bit == $past(vblank_in ^ pol_q[6]))
      else $error("vblank flag wrong");
   cb_lag_a: assert property (cb_half_delay == (demod_bypass_mode == vofc_pkg::VOFC_DEMOD_CB_LAG))
      else $error("cb lag select wrong");
   std_range_a: assert property ($past(timing_in.horiz_active_window && timing_in.enhanced_horiz_window && rng_q) |->
      pixel_out.u inside {[8'h10:8'hF0]}) else $error("chroma outside standard range");
   full_range_a: assert property ($past(timing_in.horiz_active_window && timing_in.enhanced_horiz_window && !rng_q) |->
      pixel_out.y != 8'h00 && pixel_out.y != 8'hFF) else $error("luma outside full range");
endmodule : vofc_controls_monitor
bind vofc_controls vofc_controls_monitor mon_u (.*);
